// ---- hw/cgr_regs.sv ----
// Codec gain and input routing register bank with decoded controls
//
// Contract
// - Record gain code 011111 mutes record path
// - Record codes 0-27 give 1.5 dB steps
// - Record codes 28-30 give 42/48/54 dB
// - Playback gain same codes as attenuation
// - Playback code 011111 mutes playback path
// - Analog sidetone -9 dB, 3 dB steps
// - Analog sidetone code 111 mutes
// - Digital sidetone -9 dB, 3 dB steps
// - Digital sidetone code 111 mutes
// - Headset loopthrough bit, resets clear
// - Handset loopthrough bit, resets clear
// - Caller-id input select, resets clear
// - Line input select, resets clear
// - Microphone input select, resets clear
// - Handset input select, resets clear
// - Headset input select, resets clear
`timescale 1ns/100ps
module cgr_regs
   import cgr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [CGR_AW-1:0] reg_addr,
   input wire logic [CGR_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [CGR_DW-1:0] reg_rdata,
   output logic [5:0] rec_amp_gain,
   output logic [6:0] rec_gain_hdb,
   output logic rec_mute,
   output logic [5:0] play_amp_gain,
   output logic [6:0] play_atten_hdb,
   output logic play_mute,
   output logic [2:0] analog_side_gain,
   output logic [4:0] analog_side_atten_db,
   output logic analog_side_mute,
   output logic [2:0] digital_side_gain,
   output logic [4:0] digital_side_atten_db,
   output logic digital_side_mute,
   output logic [1:0] speaker_gain_sel,
   output logic [1:0] speaker_gain_db,
   output logic headset_loopthrough,
   output logic handset_loopthrough,
   output logic callerid_in_sel,
   output logic line_in_sel,
   output logic mic_in_sel,
   output logic handset_in_sel,
   output logic headset_in_sel
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [5:0] adc_input_gain_r;
   logic [5:0] dac_playback_gain_r;
   logic [5:0] sidetone_gain_r;
   logic [1:0] speaker_gain_r;
   logic [6:0] input_routing_r;
   logic [CGR_DW-1:0] rdata_nxt;
   logic [6:0] rec_hdb_nxt;
   logic rec_mute_nxt;
   logic [6:0] play_hdb_nxt;
   logic play_mute_nxt;
   logic [4:0] aside_nxt;
   logic [4:0] dside_nxt;
   logic gain_wr;
   logic route_wr;
   logic [1:0] sub_sel;

   assign gain_wr = reg_wr && (reg_addr == CGR_ADDR_GAIN);
   assign sub_sel = reg_wdata[CGR_SUB_HI:CGR_SUB_LO];
   // Routing writes without the zero prefix are dropped, which keeps the
   // output-select sub-register that shares this address untouched
   assign route_wr = reg_wr && (reg_addr == CGR_ADDR_ROUTE) && !reg_wdata[CGR_ROUTE_SEL];

   // ----------------------------------------------------------------
   // Sub-register writes
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         adc_input_gain_r <= CGR_AMP_RST;
         dac_playback_gain_r <= CGR_AMP_RST;
         sidetone_gain_r <= CGR_SIDE_RST;
         speaker_gain_r <= CGR_SPK_RST;
      end else if (gain_wr) begin
         case (sub_sel)
            CGR_SUB_REC: adc_input_gain_r <= reg_wdata[CGR_AMP_HI:0];
            CGR_SUB_PLAY: dac_playback_gain_r <= reg_wdata[CGR_AMP_HI:0];
            CGR_SUB_SIDE: sidetone_gain_r <= reg_wdata[CGR_ASIDE_HI:0];
            CGR_SUB_SPK: speaker_gain_r <= reg_wdata[CGR_SPK_HI:CGR_SPK_LO];
            default: adc_input_gain_r <= adc_input_gain_r;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         input_routing_r <= CGR_ROUTE_RST;
      end else if (route_wr) begin
         input_routing_r <= reg_wdata[6:0];
      end
   end

   // ----------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------
   // A gain read returns the sub-register named by the prefix on the
   // write data lines, with that prefix echoed in the top bits
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_addr == CGR_ADDR_GAIN) begin
         case (sub_sel)
            CGR_SUB_REC: rdata_nxt = {CGR_SUB_REC, adc_input_gain_r};
            CGR_SUB_PLAY: rdata_nxt = {CGR_SUB_PLAY, dac_playback_gain_r};
            CGR_SUB_SIDE: rdata_nxt = {CGR_SUB_SIDE, sidetone_gain_r};
            CGR_SUB_SPK: rdata_nxt = {CGR_SUB_SPK, speaker_gain_r, 4'h0};
            default: rdata_nxt = 8'h00;
         endcase
      end else if (reg_addr == CGR_ADDR_ROUTE) begin
         rdata_nxt = {1'b0, input_routing_r};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Gain decode
   // ----------------------------------------------------------------
   cgr_amp_decode u_rec_dec (
      .code(adc_input_gain_r),
      .mag_hdb(rec_hdb_nxt),
      .mute(rec_mute_nxt)
   );

   // Same code table; the analog stage applies it as attenuation
   cgr_amp_decode u_play_dec (
      .code(dac_playback_gain_r),
      .mag_hdb(play_hdb_nxt),
      .mute(play_mute_nxt)
   );

   // Attenuation magnitude in dB: 9 + 3 * code; unused when muted
   assign aside_nxt = 5'(CGR_SIDE_BASE_DB
      + 5'(CGR_SIDE_STEP_DB * 5'(sidetone_gain_r[CGR_ASIDE_HI:CGR_ASIDE_LO])));
   assign dside_nxt = 5'(CGR_SIDE_BASE_DB
      + 5'(CGR_SIDE_STEP_DB * 5'(sidetone_gain_r[CGR_DSIDE_HI:0])));

   // ----------------------------------------------------------------
   // Registered controls to the analog section
   // ----------------------------------------------------------------
   // One flop of delay so every control pin is glitch free
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rec_amp_gain <= CGR_AMP_RST;
         rec_gain_hdb <= 7'h00;
         rec_mute <= 1'b0;
         play_amp_gain <= CGR_AMP_RST;
         play_atten_hdb <= 7'h00;
         play_mute <= 1'b0;
      end else begin
         rec_amp_gain <= adc_input_gain_r;
         rec_gain_hdb <= rec_hdb_nxt;
         rec_mute <= rec_mute_nxt;
         play_amp_gain <= dac_playback_gain_r;
         play_atten_hdb <= play_hdb_nxt;
         play_mute <= play_mute_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         analog_side_gain <= 3'h0;
         analog_side_atten_db <= CGR_SIDE_BASE_DB;
         analog_side_mute <= 1'b0;
         digital_side_gain <= 3'h0;
         digital_side_atten_db <= CGR_SIDE_BASE_DB;
         digital_side_mute <= 1'b0;
         speaker_gain_sel <= CGR_SPK_RST;
         speaker_gain_db <= 2'h0;
      end else begin
         analog_side_gain <= sidetone_gain_r[CGR_ASIDE_HI:CGR_ASIDE_LO];
         analog_side_atten_db <= aside_nxt;
         analog_side_mute <= (sidetone_gain_r[CGR_ASIDE_HI:CGR_ASIDE_LO] == CGR_SIDE_MUTE);
         digital_side_gain <= sidetone_gain_r[CGR_DSIDE_HI:0];
         digital_side_atten_db <= dside_nxt;
         digital_side_mute <= (sidetone_gain_r[CGR_DSIDE_HI:0] == CGR_SIDE_MUTE);
         speaker_gain_sel <= speaker_gain_r;
         speaker_gain_db <= speaker_gain_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         headset_loopthrough <= 1'b0;
         handset_loopthrough <= 1'b0;
         callerid_in_sel <= 1'b0;
         line_in_sel <= 1'b0;
         mic_in_sel <= 1'b0;
         handset_in_sel <= 1'b0;
         headset_in_sel <= 1'b0;
      end else begin
         headset_loopthrough <= input_routing_r[CGR_HDS_LOOP];
         handset_loopthrough <= input_routing_r[CGR_HNS_LOOP];
         callerid_in_sel <= input_routing_r[CGR_CID_IN];
         line_in_sel <= input_routing_r[CGR_LINE_IN];
         mic_in_sel <= input_routing_r[CGR_MIC_IN];
         handset_in_sel <= input_routing_r[CGR_HNS_IN];
         headset_in_sel <= input_routing_r[CGR_HDS_IN];
      end
   end
endmodule // cgr_regs

// ---- hw/cgr_pkg.sv ----
// Package: constants for the codec gain and routing register bank
package cgr_pkg;
   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int CGR_AW = 4;
   localparam int CGR_DW = 8;
   // Gain register (four sub-registers) and input routing register
   localparam logic [3:0] CGR_ADDR_GAIN = 4'h5;
   localparam logic [3:0] CGR_ADDR_ROUTE = 4'h6;
   // Sub-register selectors in bits 7:6 of a gain write
   localparam logic [1:0] CGR_SUB_REC = 2'h0;
   localparam logic [1:0] CGR_SUB_PLAY = 2'h1;
   localparam logic [1:0] CGR_SUB_SIDE = 2'h2;
   localparam logic [1:0] CGR_SUB_SPK = 2'h3;
   localparam int CGR_SUB_HI = 7;
   localparam int CGR_SUB_LO = 6;
   localparam int CGR_ROUTE_SEL = 7;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CGR_AMP_HI = 5;
   localparam int CGR_ASIDE_HI = 5;
   localparam int CGR_ASIDE_LO = 3;
   localparam int CGR_DSIDE_HI = 2;
   localparam int CGR_SPK_HI = 5;
   localparam int CGR_SPK_LO = 4;
   localparam int CGR_HDS_LOOP = 6;
   localparam int CGR_HNS_LOOP = 5;
   localparam int CGR_CID_IN = 4;
   localparam int CGR_LINE_IN = 3;
   localparam int CGR_MIC_IN = 2;
   localparam int CGR_HNS_IN = 1;
   localparam int CGR_HDS_IN = 0;
   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] CGR_AMP_MUTE = 6'h1f;
   localparam logic [5:0] CGR_AMP_FINE_MAX = 6'h1b;
   localparam logic [2:0] CGR_SIDE_MUTE = 3'h7;
   localparam logic [5:0] CGR_AMP_RST = 6'h00;
   localparam logic [5:0] CGR_SIDE_RST = 6'h00;
   localparam logic [1:0] CGR_SPK_RST = 2'h0;
   localparam logic [6:0] CGR_ROUTE_RST = 7'h00;
   // Gains in half-dB units, magnitude; coarse steps above the fine range
   localparam logic [6:0] CGR_HDB_STEP = 7'h03;
   localparam logic [6:0] CGR_HDB_42 = 7'h54;
   localparam logic [6:0] CGR_HDB_48 = 7'h60;
   localparam logic [6:0] CGR_HDB_54 = 7'h6c;
   // Sidetone attenuation in dB: base and step
   localparam logic [4:0] CGR_SIDE_BASE_DB = 5'h09;
   localparam logic [4:0] CGR_SIDE_STEP_DB = 5'h03;
endpackage

// ---- hw/cgr_amp_decode.sv ----
// Decoder: six-bit amplifier code to half-dB magnitude and mute
`timescale 1ns/100ps
module cgr_amp_decode
   import cgr_pkg::*;
(
   input wire logic [5:0] code,
   output logic [6:0] mag_hdb,
   output logic mute
);
   always_comb begin
      mute = (code == CGR_AMP_MUTE);
      mag_hdb = 7'h00;
      if (code <= CGR_AMP_FINE_MAX) begin
         // Equal steps of 1.5 dB from 0 dB
         mag_hdb = 7'((7'(code) << 1) + 7'(code));
      end else begin
         case (code)
            6'h1c: mag_hdb = CGR_HDB_42;
            6'h1d: mag_hdb = CGR_HDB_48;
            6'h1e: mag_hdb = CGR_HDB_54;
            default: mag_hdb = 7'h00;
         endcase
      end
   end
endmodule // cgr_amp_decode

// ---- testbench/cgr_regs_checker.sv ----
// Checker: timing and decode relations at the gain bank ports
`timescale 1ns/100ps
module cgr_regs_checker
   import cgr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [CGR_AW-1:0] reg_addr,
   input wire logic [CGR_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [CGR_DW-1:0] reg_rdata,
   input wire logic [5:0] rec_amp_gain,
   input wire logic [6:0] rec_gain_hdb,
   input wire logic rec_mute,
   input wire logic [5:0] play_amp_gain,
   input wire logic play_mute,
   input wire logic [2:0] analog_side_gain,
   input wire logic [4:0] analog_side_atten_db,
   input wire logic analog_side_mute,
   input wire logic [2:0] digital_side_gain,
   input wire logic digital_side_mute,
   input wire logic [1:0] speaker_gain_sel,
   input wire logic [1:0] speaker_gain_db,
   input wire logic headset_loopthrough,
   input wire logic handset_loopthrough,
   input wire logic callerid_in_sel,
   input wire logic line_in_sel,
   input wire logic mic_in_sel,
   input wire logic handset_in_sel,
   input wire logic headset_in_sel
);
   // ----
   // Write sequences
   // ----
   wire logic [6:0] route_v = {headset_loopthrough, handset_loopthrough, callerid_in_sel,
      line_in_sel, mic_in_sel, handset_in_sel, headset_in_sel};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rec_wr;
      reg_wr && reg_addr == CGR_ADDR_GAIN && reg_wdata[7:6] == CGR_SUB_REC;
   endsequence
   sequence s_route_wr;
      reg_wr && reg_addr == CGR_ADDR_ROUTE && !reg_wdata[CGR_ROUTE_SEL];
   endsequence
   chk_rec_mute: assert property (rec_mute == (rec_amp_gain == CGR_AMP_MUTE))
      else $error("record mute decode wrong");
   chk_rec_fine: assert property (rec_amp_gain <= CGR_AMP_FINE_MAX |->
      rec_gain_hdb == 7'(rec_amp_gain) * 7'h03) else $error("record fine gain wrong");
   chk_rec_coarse: assert property (rec_amp_gain == 6'h1e |-> rec_gain_hdb == 7'h6c)
      else $error("record coarse gain wrong");
   chk_play_mute: assert property (play_mute == (play_amp_gain == CGR_AMP_MUTE))
      else $error("playback mute decode wrong");
   chk_aside_step: assert property (!analog_side_mute |->
      analog_side_atten_db == 5'h09 + 5'h03 * 5'(analog_side_gain))
      else $error("analog sidetone step wrong");
   chk_aside_mute: assert property (analog_side_mute == (analog_side_gain == 3'h7))
      else $error("analog sidetone mute wrong");
   chk_dside_mute: assert property (digital_side_mute == (digital_side_gain == 3'h7))
      else $error("digital sidetone mute wrong");
   chk_spk_db: assert property (speaker_gain_db == speaker_gain_sel)
      else $error("speaker gain wrong");
   chk_rec_write: assert property (s_rec_wr |=> ##1
      {2'b00, rec_amp_gain} == ($past(reg_wdata, 2) & 8'h3f)) else $error("record write lost");
   chk_route_write: assert property (s_route_wr |=> ##1
      route_v == 7'($past(reg_wdata, 2))) else $error("routing write lost");
   chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
endmodule // cgr_regs_checker

bind cgr_regs cgr_regs_checker u_chk (.*);

// ---- testbench/cgr_host.sv ----
// Host model: drives the register port one strobe at a time
`timescale 1ns/100ps
module cgr_host
   import cgr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [CGR_DW-1:0] reg_rdata,
   output logic [CGR_AW-1:0] reg_addr,
   output logic [CGR_DW-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // ----
   // Bus cycles
   // ----
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Caller supplies the selector prefix in the top bits
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Released data never holds the last value
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] s, output logic [7:0] q);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= s;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
endmodule // cgr_host

// ---- testbench/cgr_regs_tb.sv ----
// Testbench: gain, sidetone, speaker and routing register sequences
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module cgr_regs_tb;
   import cgr_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, q;
   logic reg_wr, reg_rd, rec_mute, play_mute, analog_side_mute, digital_side_mute;
   logic [5:0] rec_amp_gain, play_amp_gain;
   logic [6:0] rec_gain_hdb, play_atten_hdb;
   logic [2:0] analog_side_gain, digital_side_gain;
   logic [4:0] analog_side_atten_db, digital_side_atten_db;
   logic [1:0] speaker_gain_sel, speaker_gain_db;
   logic headset_loopthrough, handset_loopthrough, callerid_in_sel, line_in_sel;
   logic mic_in_sel, handset_in_sel, headset_in_sel;
   int error_cnt = 0;
   int n_tests = 0;
   wire logic [6:0] route_v = {headset_loopthrough, handset_loopthrough, callerid_in_sel,
      line_in_sel, mic_in_sel, handset_in_sel, headset_in_sel};
   always #4 sys_clk = ~sys_clk;
   cgr_host host (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   cgr_regs dut (.*);
   // ----
   // Helpers
   // ----
   function automatic logic [6:0] exp_hdb(input logic [5:0] c);
      if (c <= 6'h1b) return 7'(c) * 7'h03;
      case (c)
         6'h1c: return 7'h54;
         6'h1d: return 7'h60;
         6'h1e: return 7'h6c;
         default: return 7'h00;
      endcase
   endfunction
   // Controls follow the stored value one edge later
   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      `CHK("rst_side", 5'h09, analog_side_atten_db)
      `CHK("rst_spk", 2'h0, speaker_gain_sel)
      `CHK("rst_route", 7'h00, route_v)
      for (int i = 0; i < 32; i++) begin
         host.wr(CGR_ADDR_GAIN, {CGR_SUB_REC, 6'(i)});
         host.wr(CGR_ADDR_GAIN, {CGR_SUB_PLAY, 6'(31 - i)});
         settle();
         `CHK("rec_hdb", exp_hdb(6'(i)), rec_gain_hdb)
         `CHK("rec_mute", i == 31, rec_mute)
         `CHK("play_hdb", exp_hdb(6'(31 - i)), play_atten_hdb)
         `CHK("play_mute", i == 0, play_mute)
         `CHK("play_code", 6'(31 - i), play_amp_gain)
         `CHK("rec_code", 6'(i), rec_amp_gain)
         host.rd(CGR_ADDR_GAIN, {CGR_SUB_REC, 6'h00}, q);
         `CHK("rec_rd", {CGR_SUB_REC, 6'(i)}, q)
         host.rd(CGR_ADDR_GAIN, {CGR_SUB_PLAY, 6'h00}, q);
         `CHK("play_rd", {CGR_SUB_PLAY, 6'(31 - i)}, q)
      end
      for (int i = 0; i < 8; i++) begin
         host.wr(CGR_ADDR_GAIN, {CGR_SUB_SIDE, 3'(i), 3'(7 - i)});
         settle();
         if (i < 7) `CHK("aside_db", 5'(9 + 3 * i), analog_side_atten_db)
         if (i > 0) `CHK("dside_db", 5'(30 - 3 * i), digital_side_atten_db)
         `CHK("aside_mute", i == 7, analog_side_mute)
         `CHK("dside_mute", i == 0, digital_side_mute)
         host.rd(CGR_ADDR_GAIN, {CGR_SUB_SIDE, 6'h00}, q);
         `CHK("side_rd", {CGR_SUB_SIDE, 3'(i), 3'(7 - i)}, q)
      end
      for (int i = 0; i < 4; i++) begin
         host.wr(CGR_ADDR_GAIN, {CGR_SUB_SPK, 2'(i), 4'h0});
         settle();
         `CHK("spk_db", 2'(i), speaker_gain_db)
         host.rd(CGR_ADDR_GAIN, {CGR_SUB_SPK, 6'h00}, q);
         `CHK("spk_rd", {CGR_SUB_SPK, 2'(i), 4'h0}, q)
      end
      // Walking one also proves bits 0 to 5 clear again
      for (int i = 0; i < 7; i++) begin
         host.wr(CGR_ADDR_ROUTE, 8'h01 << i);
         settle();
         `CHK("route", 7'h01 << i, route_v)
         host.rd(CGR_ADDR_ROUTE, 8'h00, q);
         `CHK("route_rd", 8'h01 << i, q)
      end
      host.wr(CGR_ADDR_ROUTE, 8'hff);
      host.wr(4'h3, 8'h00);
      settle();
      `CHK("route_refused", 7'h40, route_v)
      host.rd(4'h3, 8'h00, q);
      `CHK("unmapped_rd", 8'h00, q)
      // Reset in mid-run must clear bits that are set, not only start-up state
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      `CHK("rerst_route", 7'h00, route_v)
      `CHK("rerst_spk", 2'h0, speaker_gain_db)
      `CHK("rerst_side", 5'h09, analog_side_atten_db)
      print_verdict();
   end
endmodule // cgr_regs_tb
